// ==== src/vcm_pkg.sv ====
// Shared constants and enumerations of the vacuum condition monitor
package vcm_pkg;
   // Clock and timing
   localparam int          CLK_HZ          = 25_000_000;
   localparam int          TICK_TIME_MS    = 1;
   localparam int          MS_CYCLES       = CLK_HZ / 1000 * TICK_TIME_MS;
   localparam int          DYN_TIME_MS     = 1000;
   localparam int          LEAK_WIN_MS     = 1000;
   localparam logic [15:0] EVAC_LIMIT_MAX  = 16'h2706;
   // Register offsets
   localparam logic [7:0]  REG_CTRL        = 8'h00;
   localparam logic [7:0]  REG_STOP_TH     = 8'h04;
   localparam logic [7:0]  REG_CTRL_HYST   = 8'h08;
   localparam logic [7:0]  REG_PP_TH       = 8'h0C;
   localparam logic [7:0]  REG_PP_HYST     = 8'h10;
   localparam logic [7:0]  REG_EVAC_LIMIT  = 8'h14;
   localparam logic [7:0]  REG_LEAK_LIMIT  = 8'h18;
   localparam logic [7:0]  REG_CM_WARN     = 8'h1C;
   localparam logic [7:0]  REG_T0          = 8'h20;
   localparam logic [7:0]  REG_T1          = 8'h24;
   localparam logic [7:0]  REG_LEAK        = 8'h28;
   localparam logic [7:0]  REG_DYN         = 8'h2C;
   localparam logic [7:0]  REG_ERR_CODE    = 8'h30;
   // Control register fields
   localparam int          CTRL_MODE_BIT   = 0;
   localparam int          CTRL_AUTOSET_BIT = 1;
   // Warning byte fields
   localparam int          W_EVAC          = 1;
   localparam int          W_LEAK          = 2;
   localparam int          W_STOP          = 3;
   localparam int          W_DYN           = 4;
   localparam int          W_US            = 5;
   localparam int          W_UA            = 6;
   localparam int          W_TEMP          = 7;
   // Reset values and the dynamic pressure floor
   localparam logic [9:0]  RST_STOP_TH     = 10'h2EE;
   localparam logic [9:0]  RST_CTRL_HYST   = 10'h032;
   localparam logic [9:0]  RST_PP_TH       = 10'h226;
   localparam logic [9:0]  RST_PP_HYST     = 10'h032;
   localparam logic [15:0] RST_EVAC_LIMIT  = 16'h0000;
   localparam logic [15:0] RST_LEAK_LIMIT  = 16'h00FA;
   localparam logic [9:0]  DYN_MIN_MBAR    = 10'h005;
   // Autoset tolerances
   localparam logic [15:0] TOL_LEAK        = 16'h0032;
   localparam logic [15:0] TOL_T1          = 16'h0064;
   // Error codes, shown as two BCD digits
   localparam logic [7:0]  ERR_NONE        = 8'h00;
   localparam logic [7:0]  ERR_UA_LOW      = 8'h05;
   localparam logic [7:0]  ERR_US_LOW      = 8'h07;
   localparam logic [7:0]  ERR_UA_HIGH     = 8'h15;
   localparam logic [7:0]  ERR_OVERTEMP    = 8'h12;
   // Decimal point patterns
   localparam logic [2:0]  DP_RIGHT        = 3'h1;
   localparam logic [2:0]  DP_MID          = 3'h2;
   localparam logic [2:0]  DP_LEFT         = 3'h4;
   localparam logic [2:0]  DP_NONE         = 3'h0;
   // Identity values, arbitrary neutral digits
   localparam logic [43:0] PART_BCD        = 44'h123_4567_8901;
   localparam logic [35:0] SERIAL_BCD      = 36'h1_2345_6789;

   typedef enum logic [1:0] {CYC_IDLE, CYC_SUCK, CYC_HOLD} cyc_e;
   typedef enum logic [1:0] {MENU_OFF, MENU_SEL, MENU_VIEW} menu_e;
endpackage

// ==== src/pin_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] level
);
   typedef struct packed {
      logic [WIDTH-1:0] ff1;
      logic [WIDTH-1:0] ff2;
      logic [WIDTH-1:0] ff3;
      logic [WIDTH-1:0] out;
   } sync_s;

   sync_s st;
   sync_s next_st;

   // Level changes only when stages two and three agree
   always_comb begin
      next_st     = st;
      next_st.ff1 = pin;
      next_st.ff2 = st.ff1;
      next_st.ff3 = st.ff2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st.ff2[i] == st.ff3[i]) begin
            next_st.out[i] = st.ff3[i];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.out;
endmodule // pin_sync

// ==== src/vacuum_condition_monitor.sv ====
// Suction cycle supervision, condition warnings, errors and panel display
// Functional notes
// (RULE1) Counter view starts at units, right point flashing
// (RULE2) Up/down step counter groups, points mark group
// (RULE3) Part number shown in four groups
// (RULE4) Serial shown like counter, units first
// (RULE5) Error shows code, aborts menu, readable
// (RULE6) Overtemperature switches the device off
// (RULE7) Supply faults coded E05, E07, E15
// (RULE8) Supply error blocks menu and inputs
// (RULE9) Up button shows supply voltage during error; code does so in supply errors only, not in overtemperature
// (RULE10) Supply out of range stops vacuum
// (RULE11) Condition warnings only in IO-Link mode
// (RULE12) Stop threshold missed raises warning, yellow
// (RULE13) Missed-threshold warning from phase end on
// (RULE14) Evacuation interval over limit warns, yellow
// (RULE15) Evacuation limit up to 9.99 s, zero off
// (RULE16) Measure time to part-present level in ms
// (RULE17) Measure evacuation interval in ms
// (RULE18) Measure leak rate in control mode
// (RULE19) Low leak resumes at stop minus hysteresis
// (RULE20) High leak resumes at once, warns
// (RULE21) Dynamic pressure window warns, yellow
// (RULE22) Autoset stores last values plus tolerance
// (RULE23) Warnings packed into one byte
// (RULE24) Bits 0 to 3 clear at cycle start
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
module vacuum_condition_monitor #(
   parameter int MS_CYCLES = vcm_pkg::MS_CYCLES
) (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [15:0] rd_data,
   input  wire logic [9:0]  vacuum_mbar,
   input  wire logic [11:0] supply_bcd,
   input  wire logic        suction_in,
   input  wire logic        btn_up,
   input  wire logic        btn_down,
   input  wire logic        btn_enter,
   input  wire logic        us_low,
   input  wire logic        ua_low,
   input  wire logic        ua_high,
   input  wire logic        temp_over,
   input  wire logic        iolink_mode,
   output logic             valve_suction,
   output logic             part_present,
   output logic             status_yellow,
   output logic             shutdown,
   output logic             disp_error,
   output logic             disp_blink,
   output logic      [11:0] disp_digits,
   output logic      [2:0]  disp_dp
);
   typedef struct packed {
      vcm_pkg::cyc_e  cyc;
      vcm_pkg::menu_e menu;
      logic [14:0]    ms_cnt;
      logic [15:0]    cyc_ms;
      logic [15:0]    phase_ms;
      logic [9:0]     hold_vac;
      logic           reached_pp;
      logic           reached_stop;
      logic [7:0]     warn;
      logic [15:0]    t0;
      logic [15:0]    t1;
      logic [15:0]    leak;
      logic [15:0]    last_t1;
      logic [15:0]    last_leak;
      logic [9:0]     dyn;
      logic           control_mode;
      logic [9:0]     stop_th;
      logic [9:0]     ctrl_hyst;
      logic [9:0]     pp_th;
      logic [9:0]     pp_hyst;
      logic [15:0]    evac_limit;
      logic [15:0]    leak_limit;
      logic [35:0]    count_bcd;
      logic [3:0]     prev;
      logic [1:0]     item;
      logic [1:0]     grp;
      logic [7:0]     err_code;
      logic           valve;
      logic           present;
      logic           yellow;
      logic           off;
      logic           d_err;
      logic           d_blink;
      logic [11:0]    d_digits;
      logic [2:0]     d_dp;
      logic [15:0]    rdata;
   } state_s;

   state_s      st;
   state_s      next_st;
   logic [8:0]  pins;
   logic        s_suck;
   logic        s_up;
   logic        s_down;
   logic        s_enter;
   logic        s_us_low;
   logic        s_ua_low;
   logic        s_ua_high;
   logic        s_temp;
   logic        s_iol;

   // All panel, supply and mode pins come from outside the clock domain
   pin_sync #(
      .WIDTH (9)
   ) u_sync (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .pin     ({suction_in, btn_up, btn_down, btn_enter, us_low, ua_low, ua_high,
                 temp_over, iolink_mode}),
      .level   (pins)
   );
   assign {s_suck, s_up, s_down, s_enter, s_us_low, s_ua_low, s_ua_high, s_temp,
           s_iol} = pins;

   // Saturating difference, so thresholds near zero never wrap
   function automatic logic [9:0] sub_sat(input logic [9:0] a, input logic [9:0] b);
      sub_sat = (a > b) ? (a - b) : 10'h000;
   endfunction

   // Three BCD digits of a counter-style group, index 0 is units
   function automatic logic [11:0] bcd_grp(input logic [35:0] v, input logic [1:0] g);
      case (g)
         2'd1:    bcd_grp = v[23:12];
         2'd2:    bcd_grp = v[35:24];
         default: bcd_grp = v[11:0];
      endcase
   endfunction

   always_comb begin
      logic        tick;
      logic        sup_err;
      logic        any_err;
      logic        rise_suck;
      logic        fall_suck;
      logic        p_up;
      logic        p_down;
      logic        p_enter;
      logic        carry;
      logic [9:0]  drop;
      logic [16:0] sum;
      tick      = 1'b0;
      sup_err   = s_us_low | s_ua_low | s_ua_high;
      any_err   = sup_err | s_temp;
      rise_suck = 1'b0;
      fall_suck = 1'b0;
      p_up      = 1'b0;
      p_down    = 1'b0;
      p_enter   = 1'b0;
      carry     = 1'b0;
      drop      = 10'h000;
      sum       = 17'h0_0000;
      next_st   = st;

      // Millisecond time base
      if (st.ms_cnt >= 15'(MS_CYCLES - 1)) begin
         next_st.ms_cnt = 15'h0000;
         tick           = 1'b1;
      end else begin
         next_st.ms_cnt = st.ms_cnt + 15'h0001;
      end

      // Edges; inputs are ignored while the supply is out of range
      next_st.prev = {s_suck, s_up, s_down, s_enter};
      if (!sup_err) begin // RULE8
         rise_suck = s_suck & ~st.prev[3];
         fall_suck = ~s_suck & st.prev[3];
         p_up      = s_up & ~st.prev[2];
         p_down    = s_down & ~st.prev[1];
         p_enter   = s_enter & ~st.prev[0];
      end

      // Parts check keeps working through a supply error
      if (vacuum_mbar >= st.pp_th) begin
         next_st.present = 1'b1;
      end else if (vacuum_mbar < sub_sat(st.pp_th, st.pp_hyst)) begin
         next_st.present = 1'b0;
      end

      // Suction cycle sequencing and measurements
      if (tick && st.cyc != vcm_pkg::CYC_IDLE) begin
         next_st.cyc_ms   = (st.cyc_ms == 16'hFFFF) ? st.cyc_ms : st.cyc_ms + 16'h0001;
         next_st.phase_ms = (st.phase_ms == 16'hFFFF) ? st.phase_ms : st.phase_ms + 16'h0001;
      end
      case (st.cyc)
         vcm_pkg::CYC_IDLE: begin
            if (rise_suck) begin
               next_st.cyc          = vcm_pkg::CYC_SUCK;
               next_st.cyc_ms       = 16'h0000;
               next_st.phase_ms     = 16'h0000;
               next_st.reached_pp   = 1'b0;
               next_st.reached_stop = 1'b0;
               next_st.warn[3:0]    = 4'h0; // RULE24
               next_st.t0           = 16'h0000;
               next_st.t1           = 16'h0000;
               next_st.leak         = 16'h0000;
               // Cycle counter in BCD so the panel needs no divider
               carry = 1'b1;
               for (int d = 0; d < 9; d++) begin
                  if (carry) begin
                     if (st.count_bcd[d*4 +: 4] == 4'h9) begin
                        next_st.count_bcd[d*4 +: 4] = 4'h0;
                     end else begin
                        next_st.count_bcd[d*4 +: 4] = st.count_bcd[d*4 +: 4] + 4'h1;
                        carry = 1'b0;
                     end
                  end
               end
            end
         end
         vcm_pkg::CYC_SUCK: begin
            if (!st.reached_pp && vacuum_mbar >= st.pp_th) begin
               next_st.reached_pp = 1'b1;
               next_st.t0         = st.cyc_ms; // RULE16
               next_st.phase_ms   = 16'h0000;
            end
            if (st.reached_pp && !st.reached_stop && vacuum_mbar >= st.stop_th) begin
               next_st.reached_stop = 1'b1;
               next_st.t1           = st.phase_ms; // RULE17
               next_st.last_t1      = st.phase_ms;
               if (s_iol && st.evac_limit != 16'h0000 && st.phase_ms > st.evac_limit) begin
                  next_st.warn[vcm_pkg::W_EVAC] = 1'b1; // RULE14 RULE15
               end
            end
            // Dynamic pressure: free suction sampled once per cycle
            if (tick && st.cyc_ms == 16'(vcm_pkg::DYN_TIME_MS - 1) && !st.reached_pp &&
                vacuum_mbar >= vcm_pkg::DYN_MIN_MBAR && vacuum_mbar <= st.stop_th) begin
               next_st.dyn = vacuum_mbar; // RULE21
               next_st.warn[vcm_pkg::W_DYN] = s_iol &&
                  (vacuum_mbar > sub_sat(st.pp_th, st.pp_hyst)) && (vacuum_mbar < st.stop_th);
            end
            if (st.control_mode && st.reached_stop) begin
               next_st.cyc      = vcm_pkg::CYC_HOLD;
               next_st.hold_vac = vacuum_mbar;
               next_st.phase_ms = 16'h0000;
            end
         end
         vcm_pkg::CYC_HOLD: begin
            drop = sub_sat(st.hold_vac, vacuum_mbar);
            if (vacuum_mbar < sub_sat(st.stop_th, st.ctrl_hyst)) begin
               next_st.cyc = vcm_pkg::CYC_SUCK; // RULE19
               next_st.reached_stop = 1'b0;
               next_st.reached_pp   = 1'b1;
            end else if (tick && st.phase_ms == 16'(vcm_pkg::LEAK_WIN_MS - 1)) begin
               // Window of one second, so the drop is already mbar per second
               next_st.leak      = {6'h00, drop}; // RULE18
               next_st.last_leak = {6'h00, drop};
               next_st.hold_vac  = vacuum_mbar;
               next_st.phase_ms  = 16'h0000;
               if ({6'h00, drop} > st.leak_limit) begin
                  next_st.cyc                   = vcm_pkg::CYC_SUCK; // RULE20
                  next_st.reached_stop          = 1'b0;
                  next_st.warn[vcm_pkg::W_LEAK] = s_iol;
               end
            end
         end
         default: begin
            next_st.cyc = vcm_pkg::CYC_IDLE;
         end
      endcase
      // End of suction phase; an error also ends it
      if (st.cyc != vcm_pkg::CYC_IDLE && (fall_suck || any_err)) begin
         next_st.cyc = vcm_pkg::CYC_IDLE;
         if (s_iol && !st.reached_stop) begin
            next_st.warn[vcm_pkg::W_STOP] = 1'b1; // RULE12 RULE13
         end
      end

      // Continuous supply and temperature bits
      next_st.warn[0]             = 1'b0; // RULE23
      next_st.warn[vcm_pkg::W_US] = s_iol & s_us_low;
      next_st.warn[vcm_pkg::W_UA] = s_iol & (s_ua_low | s_ua_high);
      next_st.warn[vcm_pkg::W_TEMP] = s_iol & s_temp;
      if (!s_iol) begin
         next_st.warn = 8'h00; // RULE11
      end
      next_st.yellow = |next_st.warn[vcm_pkg::W_DYN:vcm_pkg::W_EVAC];

      // Valve and self protection
      next_st.valve = (next_st.cyc == vcm_pkg::CYC_SUCK) && !any_err; // RULE10
      next_st.off   = s_temp; // RULE6

      // Error code with fixed priority
      if (s_ua_low) begin
         next_st.err_code = vcm_pkg::ERR_UA_LOW; // RULE7
      end else if (s_us_low) begin
         next_st.err_code = vcm_pkg::ERR_US_LOW; // RULE7
      end else if (s_ua_high) begin
         next_st.err_code = vcm_pkg::ERR_UA_HIGH; // RULE7
      end else if (s_temp) begin
         next_st.err_code = vcm_pkg::ERR_OVERTEMP;
      end else begin
         next_st.err_code = vcm_pkg::ERR_NONE;
      end

      // Panel menu: item 0 counter, 1 serial, 2 part number, 3 close
      case (st.menu)
         vcm_pkg::MENU_OFF: begin
            if (p_enter) begin
               next_st.menu = vcm_pkg::MENU_SEL;
               next_st.item = 2'd0;
            end
         end
         vcm_pkg::MENU_SEL: begin
            if (p_up) begin
               next_st.item = st.item + 2'd1;
            end else if (p_down) begin
               next_st.item = st.item - 2'd1;
            end else if (p_enter) begin
               next_st.menu = (st.item == 2'd3) ? vcm_pkg::MENU_OFF : vcm_pkg::MENU_VIEW;
               next_st.grp  = 2'd0; // RULE1 RULE3 RULE4
            end
         end
         vcm_pkg::MENU_VIEW: begin
            if (p_enter) begin
               next_st.menu = vcm_pkg::MENU_SEL;
            end else if (p_up && st.grp != ((st.item == 2'd2) ? 2'd3 : 2'd2)) begin
               next_st.grp = st.grp + 2'd1; // RULE2
            end else if (p_down && st.grp != 2'd0) begin
               next_st.grp = st.grp - 2'd1; // RULE2
            end
         end
         default: begin
            next_st.menu = vcm_pkg::MENU_OFF;
         end
      endcase
      if (any_err) begin
         next_st.menu = vcm_pkg::MENU_OFF; // RULE5 RULE8
      end

      // Display contents
      next_st.d_err    = 1'b0;
      next_st.d_blink  = 1'b0;
      next_st.d_dp     = vcm_pkg::DP_NONE;
      next_st.d_digits = 12'h000;
      if (sup_err && s_up) begin
         next_st.d_digits = supply_bcd; // RULE9
      end else if (any_err) begin
         next_st.d_err    = 1'b1; // RULE5
         next_st.d_digits = {4'h0, next_st.err_code};
      end else if (st.menu == vcm_pkg::MENU_SEL) begin
         next_st.d_digits = {10'h000, st.item};
      end else if (st.menu == vcm_pkg::MENU_VIEW) begin
         if (st.item == 2'd2) begin
            case (st.grp) // RULE3
               2'd0:    next_st.d_digits = {4'h0, vcm_pkg::PART_BCD[43:36]};
               2'd1:    next_st.d_digits = vcm_pkg::PART_BCD[35:24];
               2'd2:    next_st.d_digits = vcm_pkg::PART_BCD[23:12];
               default: next_st.d_digits = vcm_pkg::PART_BCD[11:0];
            endcase
            case (st.grp)
               2'd0:    next_st.d_dp = vcm_pkg::DP_RIGHT;
               2'd3:    next_st.d_dp = vcm_pkg::DP_NONE;
               default: next_st.d_dp = vcm_pkg::DP_LEFT;
            endcase
         end else begin
            next_st.d_digits = bcd_grp((st.item == 2'd0) ? st.count_bcd :
                                       vcm_pkg::SERIAL_BCD, st.grp); // RULE1 RULE4
            case (st.grp) // RULE2
               2'd0:    next_st.d_dp = vcm_pkg::DP_RIGHT;
               2'd1:    next_st.d_dp = vcm_pkg::DP_MID;
               default: next_st.d_dp = vcm_pkg::DP_LEFT;
            endcase
            next_st.d_blink = (st.grp == 2'd0); // RULE1 RULE4
         end
      end

      // Register writes; autoset is a self-clearing command bit
      if (wr_en) begin
         case (addr)
            vcm_pkg::REG_CTRL: begin
               next_st.control_mode = wr_data[vcm_pkg::CTRL_MODE_BIT];
               if (wr_data[vcm_pkg::CTRL_AUTOSET_BIT]) begin
                  sum                = {1'b0, st.last_leak} + {1'b0, vcm_pkg::TOL_LEAK};
                  next_st.leak_limit = sum[16] ? 16'hFFFF : sum[15:0]; // RULE22
                  sum = {1'b0, st.last_t1} + {1'b0, vcm_pkg::TOL_T1};
                  next_st.evac_limit = (sum > {1'b0, vcm_pkg::EVAC_LIMIT_MAX}) ?
                                       vcm_pkg::EVAC_LIMIT_MAX : sum[15:0]; // RULE22
               end
            end
            vcm_pkg::REG_STOP_TH:    next_st.stop_th    = wr_data[9:0];
            vcm_pkg::REG_CTRL_HYST:  next_st.ctrl_hyst  = wr_data[9:0];
            vcm_pkg::REG_PP_TH:      next_st.pp_th      = wr_data[9:0];
            vcm_pkg::REG_PP_HYST:    next_st.pp_hyst    = wr_data[9:0];
            vcm_pkg::REG_EVAC_LIMIT: next_st.evac_limit = (wr_data > vcm_pkg::EVAC_LIMIT_MAX) ?
                                        vcm_pkg::EVAC_LIMIT_MAX : wr_data; // RULE15
            vcm_pkg::REG_LEAK_LIMIT: next_st.leak_limit = wr_data;
            default: begin
            end
         endcase
      end

      // Register reads, data valid in the following cycle only
      next_st.rdata = 16'h0000;
      if (rd_en) begin
         case (addr)
            vcm_pkg::REG_CTRL:       next_st.rdata = {15'h0000, st.control_mode};
            vcm_pkg::REG_STOP_TH:    next_st.rdata = {6'h00, st.stop_th};
            vcm_pkg::REG_CTRL_HYST:  next_st.rdata = {6'h00, st.ctrl_hyst};
            vcm_pkg::REG_PP_TH:      next_st.rdata = {6'h00, st.pp_th};
            vcm_pkg::REG_PP_HYST:    next_st.rdata = {6'h00, st.pp_hyst};
            vcm_pkg::REG_EVAC_LIMIT: next_st.rdata = st.evac_limit;
            vcm_pkg::REG_LEAK_LIMIT: next_st.rdata = st.leak_limit;
            vcm_pkg::REG_CM_WARN:    next_st.rdata = {8'h00, st.warn}; // RULE23
            vcm_pkg::REG_T0:         next_st.rdata = st.t0;
            vcm_pkg::REG_T1:         next_st.rdata = st.t1;
            vcm_pkg::REG_LEAK:       next_st.rdata = st.leak; // RULE18
            vcm_pkg::REG_DYN:        next_st.rdata = {6'h00, st.dyn};
            vcm_pkg::REG_ERR_CODE:   next_st.rdata = {8'h00, st.err_code}; // RULE5
            default:                 next_st.rdata = 16'h0000;
         endcase
      end
   end

   // Single state register; configuration takes its defaults here
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st            <= '0;
         st.cyc        <= vcm_pkg::CYC_IDLE;
         st.menu       <= vcm_pkg::MENU_OFF;
         st.stop_th    <= vcm_pkg::RST_STOP_TH;
         st.ctrl_hyst  <= vcm_pkg::RST_CTRL_HYST;
         st.pp_th      <= vcm_pkg::RST_PP_TH;
         st.pp_hyst    <= vcm_pkg::RST_PP_HYST;
         st.evac_limit <= vcm_pkg::RST_EVAC_LIMIT;
         st.leak_limit <= vcm_pkg::RST_LEAK_LIMIT;
      end else begin
         st <= next_st;
      end
   end

   assign rd_data       = st.rdata;
   assign valve_suction = st.valve;
   assign part_present  = st.present;
   assign status_yellow = st.yellow;
   assign shutdown      = st.off;
   assign disp_error    = st.d_err;
   assign disp_blink    = st.d_blink;
   assign disp_digits   = st.d_digits;
   assign disp_dp       = st.d_dp;
endmodule // vacuum_condition_monitor

// ==== sim/vcm_props.sv ====
// Concurrent checks on fault, panel and warning outputs of the monitor
`timescale 1ns/1ps
module vcm_props (
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic        ua_low,
   input wire logic        temp_over,
   input wire logic        btn_up,
   input wire logic        iolink_mode,
   input wire logic [11:0] supply_bcd,
   input wire logic        valve_suction,
   input wire logic        status_yellow,
   input wire logic        shutdown,
   input wire logic        disp_error,
   input wire logic        disp_blink,
   input wire logic [11:0] disp_digits,
   input wire logic [2:0]  disp_dp
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Eight cycles cover the pin filter, edge detect and output flop
   a_valve_off: assert property ($rose(ua_low) |-> ##[1:8] !valve_suction)
      else $error("valve on in fault");
   a_fault_hold: assert property (ua_low[*8] |-> !valve_suction)
      else $error("valve on in fault");
   a_err_code: assert property ((ua_low && !btn_up)[*8] |->
      disp_error && disp_digits[7:0] == 8'h05)
      else $error("wrong error code");
   a_up_volt: assert property ((ua_low && btn_up)[*8] |->
      !disp_error && disp_digits == supply_bcd)
      else $error("supply not shown");
   a_heat_off: assert property (temp_over[*8] |-> shutdown)
      else $error("no shutdown");
   a_heat_ok: assert property (!temp_over[*8] |-> !shutdown)
      else $error("false shutdown");
   a_cm_idle: assert property (!iolink_mode[*8] |-> !status_yellow)
      else $error("yellow outside link mode");
   a_blink_dp: assert property (disp_blink |-> disp_dp == 3'h1)
      else $error("blink without right point");
endmodule // vcm_props

// ==== sim/vacuum_plant.sv ====
// Behavioural vacuum source: rises while the valve sucks, vents at once
`timescale 1ns/1ps
module vacuum_plant (
   input  wire logic       clk_sys,
   input  wire logic       valve_suction,
   input  wire logic [9:0] cap,
   output logic      [9:0] vacuum_mbar = 10'h000
);
   logic [1:0] div = 2'b00;
   // One mbar per fourth clock up to the cap, so thresholds are crossed slowly
   always @(posedge clk_sys) begin
      div <= div + 2'b01;
      if (!valve_suction) vacuum_mbar <= 10'h000;
      else if (div == 2'b00 && vacuum_mbar < cap) vacuum_mbar <= vacuum_mbar + 10'h001;
   end
endmodule // vacuum_plant

// ==== sim/vacuum_condition_monitor_tb.sv ====
// Directed bench: suction cycles, counter view, supply faults and overtemperature
`timescale 1ns/1ps
module vacuum_condition_monitor_tb;
   logic clk_sys = 0, resetn = 0, wr_en = 0, rd_en = 0, suction_in = 0, btn_up = 0;
   logic btn_down = 0, btn_enter = 0, us_low = 0, ua_low = 0, ua_high = 0, temp_over = 0;
   logic iolink_mode = 1, valve_suction, part_present, status_yellow, shutdown;
   logic disp_error, disp_blink;
   logic [2:0] disp_dp;
   logic [7:0] addr = 8'h00;
   logic [9:0] vacuum_mbar, cap = 10'h000;
   logic [11:0] supply_bcd = 12'h240, disp_digits;
   logic [15:0] wr_data = 16'h0000, rd_data, v;
   int err_total = 0, num_checks = 0, ticks = 0;
   vacuum_condition_monitor #(.MS_CYCLES(10)) u_dut (.*);
   vacuum_plant u_plant (.*);
   // Clock, and a hang guard well above the ~13k cycles the tests need
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (++ticks == 20000) begin err_total++; test_done; end
   task automatic tk(input int n); repeat (n) @(posedge clk_sys); endtask
   task automatic chk(input logic [15:0] s, e);
      num_checks++;
      if (s !== e) begin err_total++; $display("CHECK FAILED %0t %h %h", $time, s, e); end
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      addr <= a; rd_en <= 1'b1; tk(1);
      rd_en <= 1'b0; #1 v = rd_data; tk(1);
   endtask
   task automatic press(input logic [2:0] m);
      {btn_enter, btn_up, btn_down} <= m; tk(8);
      {btn_enter, btn_up, btn_down} <= 3'b000; tk(8);
   endtask
   task automatic t_cyc(input logic [9:0] c, input logic [15:0] lim, w);
      addr <= vcm_pkg::REG_EVAC_LIMIT; wr_data <= lim; wr_en <= 1'b1; tk(1);
      wr_en <= 1'b0; cap <= c; suction_in <= 1'b1; tk(4000);
      chk({15'h0, part_present}, 16'h0001);
      suction_in <= 1'b0; tk(20); rd(vcm_pkg::REG_CM_WARN);
      chk(v, w);
      chk({15'h0, status_yellow}, {15'h0, |w});
      suction_in <= 1'b1; tk(20); rd(vcm_pkg::REG_CM_WARN);
      chk(v, 16'h0000);
      suction_in <= 1'b0; tk(20);
      $display("cycle test done");
   endtask
   task automatic t_panel;
      press(3'b100); press(3'b100);
      chk({disp_blink, disp_dp, disp_digits}, 16'h9006);
      press(3'b010);
      chk({disp_blink, disp_dp, disp_digits}, 16'h2000);
      press(3'b001);
      chk({disp_blink, disp_dp, disp_digits}, 16'h9006);
      press(3'b100); press(3'b010); press(3'b100);
      chk({disp_blink, disp_dp, disp_digits}, {4'h9, vcm_pkg::SERIAL_BCD[11:0]});
      $display("panel test done");
   endtask
   task automatic t_fault;
      logic [7:0] ec [4] = '{8'h05, 8'h07, 8'h15, 8'h12};
      logic [7:0] wb [4] = '{8'h48, 8'h28, 8'h48, 8'h88};
      for (int i = 0; i < 4; i++) begin
         suction_in <= 1'b1; tk(20);
         {temp_over, ua_high, us_low, ua_low} <= 4'b0001 << i; tk(10);
         chk({disp_error, valve_suction, 6'h00, disp_digits[7:0]}, {8'h80, ec[i]});
         rd(vcm_pkg::REG_ERR_CODE);
         chk(v, {8'h00, ec[i]});
         rd(vcm_pkg::REG_CM_WARN);
         chk(v, {8'h00, wb[i]});
         btn_up <= 1'b1; tk(10);
         if (i < 3) chk({4'h0, disp_digits}, {4'h0, supply_bcd});
         chk({15'h0, shutdown}, 16'(i == 3));
         {temp_over, ua_high, us_low, ua_low, btn_up, suction_in} <= 6'h00; tk(10);
      end
      $display("fault test done");
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Six cycles run before the counter is viewed
   initial begin
      tk(10); resetn <= 1'b1; tk(2);
      t_cyc(10'h3FF, 16'h0001, 16'h0002);
      t_cyc(10'h258, 16'h0000, 16'h0008);
      iolink_mode <= 1'b0;
      t_cyc(10'h258, 16'h0000, 16'h0000);
      iolink_mode <= 1'b1;
      t_panel; t_fault; test_done;
   end
endmodule // vacuum_condition_monitor_tb
bind vacuum_condition_monitor vcm_props u_props (.*);
